/* design/fbp_cfg.svh */
// flash block erase/protect constants: sizes, address fields, erase values
`ifndef FBP_CFG_SVH
`define FBP_CFG_SVH

// =====================================================================
// array geometry
`define FBP_FLASH_BYTES 131072
`define FBP_ADDR_W 17
`define FBP_DATA_W 32
`define FBP_WORDS 32768
`define FBP_IDX_W 15
`define FBP_UNITS 64
`define FBP_BLK_W 7
`define FBP_CNT_W 8

// =====================================================================
// byte address fields
`define FBP_IDX_MSB 16
`define FBP_IDX_LSB 2
`define FBP_BLK_MSB 16
`define FBP_BLK_LSB 10
`define FBP_UNIT_MSB 16
`define FBP_UNIT_LSB 11

// =====================================================================
// values and counts
`define FBP_ERASED 32'hffffffff
`define FBP_DENIED_DATA 32'h00000000
`define FBP_CNT_FIRST 8'h00
`define FBP_CNT_LAST 8'hff
`define FBP_CHK_READ 0
`define FBP_CHK_CMD 1

`endif

/* design/fbp_pkg.sv */
// flash block erase/protect types
`include "fbp_cfg.svh"

package fbp_pkg;

  typedef enum logic [0:0] {
    FBP_ST_IDLE = 1'b0,
    FBP_ST_ERASE = 1'b1
  } fbp_state_t;

  typedef enum logic [0:0] {
    FBP_OP_PROG = 1'b0,
    FBP_OP_ERASE = 1'b1
  } fbp_op_t;

  typedef struct packed {
    fbp_state_t state;
    logic [`FBP_BLK_W-1:0] ers_blk;
    logic [`FBP_CNT_W-1:0] ers_cnt;
    logic [`FBP_DATA_W-1:0] f_data;
    logic f_ack;
    logic [`FBP_DATA_W-1:0] r_data;
    logic r_ack;
    logic r_err;
    logic c_done;
    logic c_err;
    logic viol;
  } fbp_ctl_t;

endpackage : fbp_pkg

/* design/fbp_chk_if.sv */
// protection lookup channels between controller and lookup
`include "fbp_cfg.svh"

interface fbp_chk_if;
  logic [1:0][`FBP_ADDR_W-1:0] addr;
  logic [1:0] deny;

  modport lookup (
    input addr,
    output deny
  );

  modport user (
    output addr,
    input deny
  );
endinterface : fbp_chk_if

/* design/fbp_prot_lookup.sv */
// per-unit protection lookup for the read and command channels
`include "fbp_cfg.svh"

module fbp_prot_lookup (
  input wire logic [`FBP_UNITS-1:0] prot_ro_in,
  input wire logic [`FBP_UNITS-1:0] prot_xo_in,
  fbp_chk_if.lookup chk
);

  // =====================================================================
  // lookup channels
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chk
      logic [`FBP_UNIT_MSB-`FBP_UNIT_LSB:0] unit;
      assign unit = chk.addr[g][`FBP_UNIT_MSB:`FBP_UNIT_LSB];
      if (g == `FBP_CHK_CMD) begin : g_cmd
        assign chk.deny[g] = prot_ro_in[unit] | prot_xo_in[unit];
      end else begin : g_rd
        assign chk.deny[g] = prot_xo_in[unit];
      end
    end
  endgenerate

endmodule // fbp_prot_lookup

/* design/fbp_top.sv */
// flash array with block erase, program and per-unit protection
`include "fbp_cfg.svh"

// Notes on behaviour
// - flash holds 128 KB, reachable for read, program and erase.
// - each 1 KB block erases alone, other blocks untouched.
// - an erased block reads all ones.
// - two adjacent erase blocks share one protection setting.
// - read-only units refuse erase and program, contents kept.
// - execute-only units also refuse erase and program.
// - execute-only units serve fetches only; data and debug reads denied.
module fbp_top (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [`FBP_UNITS-1:0] prot_ro_in,
  input wire logic [`FBP_UNITS-1:0] prot_xo_in,
  input wire logic fetch_req_in,
  input wire logic [`FBP_ADDR_W-1:0] fetch_addr_in,
  output logic fetch_ack_out,
  output logic [`FBP_DATA_W-1:0] fetch_data_out,
  input wire logic rd_req_in,
  input wire logic rd_dbg_in,
  input wire logic [`FBP_ADDR_W-1:0] rd_addr_in,
  output logic rd_ack_out,
  output logic rd_err_out,
  output logic [`FBP_DATA_W-1:0] rd_data_out,
  input wire logic cmd_valid_in,
  input wire logic cmd_op_in,
  input wire logic [`FBP_ADDR_W-1:0] cmd_addr_in,
  input wire logic [`FBP_DATA_W-1:0] cmd_data_in,
  output logic cmd_ready_out,
  output logic cmd_done_out,
  output logic cmd_err_out,
  output logic viol_out,
  input wire logic viol_clear_in
);

  // =====================================================================
  // state and storage
  fbp_pkg::fbp_ctl_t ctl_reg;
  fbp_pkg::fbp_ctl_t ctl_next;
  logic [`FBP_DATA_W-1:0] mem_reg [`FBP_WORDS];
  logic mem_we;
  logic [`FBP_IDX_W-1:0] mem_widx;
  logic [`FBP_DATA_W-1:0] mem_wdata;
  logic [`FBP_IDX_W-1:0] fetch_idx;
  logic [`FBP_IDX_W-1:0] rd_idx;
  logic [`FBP_IDX_W-1:0] cmd_idx;
  logic cmd_accept;
  logic rd_deny;
  logic cmd_deny;
  fbp_pkg::fbp_op_t cmd_op;

  fbp_chk_if chk ();

  // =====================================================================
  // protection lookup
  assign chk.addr[`FBP_CHK_READ] = rd_addr_in;
  assign chk.addr[`FBP_CHK_CMD] = cmd_addr_in;
  fbp_prot_lookup u_lookup (
    .prot_ro_in(prot_ro_in),
    .prot_xo_in(prot_xo_in),
    .chk(chk)
  );
  assign rd_deny = chk.deny[`FBP_CHK_READ];
  assign cmd_deny = chk.deny[`FBP_CHK_CMD];

  assign fetch_idx = fetch_addr_in[`FBP_IDX_MSB:`FBP_IDX_LSB];
  assign rd_idx = rd_addr_in[`FBP_IDX_MSB:`FBP_IDX_LSB];
  assign cmd_idx = cmd_addr_in[`FBP_IDX_MSB:`FBP_IDX_LSB];
  assign cmd_op = fbp_pkg::fbp_op_t'(cmd_op_in);
  // new commands wait while an erase walks its block
  assign cmd_ready_out = (ctl_reg.state == fbp_pkg::FBP_ST_IDLE);
  assign cmd_accept = cmd_valid_in & cmd_ready_out;

  // =====================================================================
  // next state
  always_comb begin
    ctl_next = ctl_reg;
    mem_we = 1'b0;
    mem_widx = cmd_idx;
    mem_wdata = mem_reg[cmd_idx] & cmd_data_in;
    ctl_next.c_done = 1'b0;
    ctl_next.c_err = 1'b0;
    ctl_next.f_ack = fetch_req_in;
    if (fetch_req_in) begin
      ctl_next.f_data = mem_reg[fetch_idx];
    end
    ctl_next.r_ack = rd_req_in;
    ctl_next.r_err = rd_req_in & rd_deny;
    if (rd_req_in) begin
      ctl_next.r_data = rd_deny ? `FBP_DENIED_DATA : mem_reg[rd_idx];
    end
    case (ctl_reg.state)
      fbp_pkg::FBP_ST_IDLE: begin
        if (cmd_accept) begin
          if (cmd_deny) begin
            ctl_next.c_err = 1'b1;
          end else if (cmd_op == fbp_pkg::FBP_OP_ERASE) begin
            ctl_next.state = fbp_pkg::FBP_ST_ERASE;
            ctl_next.ers_blk = cmd_addr_in[`FBP_BLK_MSB:`FBP_BLK_LSB];
            ctl_next.ers_cnt = `FBP_CNT_FIRST;
          end else begin
            // programming only clears bits
            mem_we = 1'b1;
            ctl_next.c_done = 1'b1;
          end
        end
      end
      fbp_pkg::FBP_ST_ERASE: begin
        mem_we = 1'b1;
        mem_widx = {ctl_reg.ers_blk, ctl_reg.ers_cnt};
        mem_wdata = `FBP_ERASED;
        ctl_next.ers_cnt = ctl_reg.ers_cnt + 8'h01;
        if (ctl_reg.ers_cnt == `FBP_CNT_LAST) begin
          ctl_next.state = fbp_pkg::FBP_ST_IDLE;
          ctl_next.c_done = 1'b1;
        end
      end
      default: begin
        ctl_next.state = fbp_pkg::FBP_ST_IDLE;
      end
    endcase
    if ((rd_req_in & rd_deny) | (cmd_accept & cmd_deny)) begin
      ctl_next.viol = 1'b1;
    end else if (viol_clear_in) begin
      ctl_next.viol = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ctl_reg <= '0;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // array is nonvolatile, so reset leaves it alone
  always_ff @(posedge sys_clk_in) begin
    if (mem_we) begin
      mem_reg[mem_widx] <= mem_wdata;
    end
  end

  // =====================================================================
  // outputs
  assign fetch_ack_out = ctl_reg.f_ack;
  assign fetch_data_out = ctl_reg.f_data;
  assign rd_ack_out = ctl_reg.r_ack;
  assign rd_err_out = ctl_reg.r_err;
  assign rd_data_out = ctl_reg.r_data;
  assign cmd_done_out = ctl_reg.c_done;
  assign cmd_err_out = ctl_reg.c_err;
  assign viol_out = ctl_reg.viol;

  // =====================================================================
  // assertions
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  logic rd_xo;
  logic cmd_prot;
  logic [`FBP_IDX_W-1:0] last_prog_idx;
  logic [`FBP_DATA_W-1:0] last_prog_val;
  assign rd_xo = prot_xo_in[rd_addr_in[`FBP_UNIT_MSB:`FBP_UNIT_LSB]];
  assign cmd_prot = prot_ro_in[cmd_addr_in[`FBP_UNIT_MSB:`FBP_UNIT_LSB]] |
                    prot_xo_in[cmd_addr_in[`FBP_UNIT_MSB:`FBP_UNIT_LSB]];

  always_ff @(posedge sys_clk_in) begin
    if (cmd_accept) begin
      last_prog_idx <= cmd_idx;
      last_prog_val <= mem_reg[cmd_idx] & cmd_data_in;
    end
  end

  read_deny_a: assert property (rd_req_in && rd_xo |=>
    rd_ack_out && rd_err_out && rd_data_out == `FBP_DENIED_DATA)
    else $error("execute-only data read not denied");

  read_allow_a: assert property (rd_req_in && !rd_xo |=> rd_ack_out && !rd_err_out)
    else $error("open data read refused");

  fetch_serve_a: assert property (fetch_req_in |=>
    fetch_ack_out && fetch_data_out == $past(mem_reg[fetch_idx]))
    else $error("fetch not served with array word");

  cmd_refuse_a: assert property (cmd_accept && cmd_prot |=>
    cmd_err_out && !cmd_done_out && cmd_ready_out)
    else $error("protected command not refused");

  cmd_nowrite_a: assert property (cmd_accept && cmd_prot |-> !mem_we)
    else $error("protected command wrote the array");

  erase_len_a: assert property (cmd_accept && !cmd_prot && cmd_op_in |->
    ##1 (!cmd_ready_out && !cmd_done_out) [*8] ##248 !cmd_done_out ##1 cmd_done_out)
    else $error("erase did not take 256 word cycles");

  erase_ones_a: assert property (ctl_reg.state == fbp_pkg::FBP_ST_ERASE |-> mem_we &&
    mem_wdata == `FBP_ERASED && mem_widx[`FBP_IDX_W-1:`FBP_CNT_W] == ctl_reg.ers_blk)
    else $error("erase wrote outside block or not ones");

  prog_write_a: assert property (cmd_accept && !cmd_prot && !cmd_op_in |=>
    cmd_done_out && mem_reg[last_prog_idx] == last_prog_val)
    else $error("program word not stored");

  viol_set_a: assert property ((rd_req_in && rd_xo) || (cmd_accept && cmd_prot) |=>
    viol_out)
    else $error("violation flag not set");

  viol_hold_a: assert property (viol_out && !viol_clear_in |=> viol_out)
    else $error("violation flag dropped without clear");

  erase_done_c: cover property (ctl_reg.state == fbp_pkg::FBP_ST_ERASE ##1 cmd_done_out);
  prog_done_c: cover property (cmd_accept && !cmd_op_in ##1 cmd_done_out);
  dbg_deny_c: cover property (rd_req_in && rd_dbg_in && rd_xo ##1 rd_err_out);
  cmd_deny_c: cover property (cmd_accept && cmd_prot ##1 cmd_err_out);

endmodule // fbp_top

/* design/fbp_top_unused_placeholder.sv */
// (intentionally empty)

/* testbench/fbp_host_model.sv */
// processor fetch and data-read master model
`include "fbp_cfg.svh"

module fbp_host_model (
  input wire logic clk_in,
  input wire logic fetch_ack_in,
  input wire logic [`FBP_DATA_W-1:0] fetch_data_in,
  input wire logic rd_ack_in,
  input wire logic rd_err_in,
  input wire logic [`FBP_DATA_W-1:0] rd_data_in,
  output logic fetch_req_out,
  output logic [`FBP_ADDR_W-1:0] fetch_addr_out,
  output logic rd_req_out,
  output logic rd_dbg_out,
  output logic [`FBP_ADDR_W-1:0] rd_addr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    fetch_req_out = 1'b0;
    fetch_addr_out = '0;
    rd_req_out = 1'b0;
    rd_dbg_out = 1'b0;
    rd_addr_out = '0;
  end
  // =====================================================
  // requests last one cycle, answer taken at the next edge
  task automatic fetch(input logic [`FBP_ADDR_W-1:0] a, output logic [`FBP_DATA_W-1:0] d);
    @(posedge clk_in) #1;
    fetch_req_out = 1'b1;
    fetch_addr_out = a;
    @(posedge clk_in) #1;
    fetch_req_out = 1'b0;
    // idle address flips so a stale value is never trusted
    fetch_addr_out = ~a;
    d = fetch_ack_in ? fetch_data_in : 'x;
  endtask
  task automatic read(input logic [`FBP_ADDR_W-1:0] a, input logic dbg,
                      output logic [`FBP_DATA_W-1:0] d, output logic e);
    @(posedge clk_in) #1;
    rd_req_out = 1'b1;
    rd_dbg_out = dbg;
    rd_addr_out = a;
    @(posedge clk_in) #1;
    rd_req_out = 1'b0;
    rd_dbg_out = ~dbg;
    rd_addr_out = ~a;
    d = rd_ack_in ? rd_data_in : 'x;
    e = rd_ack_in ? rd_err_in : 1'bx;
  endtask
endmodule // fbp_host_model

/* testbench/tb.sv */
// self-checking bench for the flash erase and protection block
`include "fbp_cfg.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic op;
    logic [16:0] a;
    logic [31:0] d;
    logic ro;
    logic xo;
    logic err;
  } fbp_row_t;
  logic sys_clk_in, reset_in, cmd_valid_in, cmd_op_in, viol_clear_in, e;
  logic [63:0] prot_ro_in, prot_xo_in;
  logic [16:0] cmd_addr_in, f_addr, r_addr;
  logic [31:0] cmd_data_in, f_data, r_data, d;
  logic f_req, f_ack, r_req, r_dbg, r_ack, r_err, c_rdy, c_done, c_err, viol;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int n, k;
  logic [31:0] exp_mem [int];
  fbp_row_t rows [10] = '{
    '{1'b1, 17'h00000, 32'h0, 1'b0, 1'b0, 1'b0},
    '{1'b1, 17'h00400, 32'h0, 1'b0, 1'b0, 1'b0},
    '{1'b1, 17'h01000, 32'h0, 1'b0, 1'b0, 1'b0},
    '{1'b0, 17'h00004, 32'h1234abcd, 1'b0, 1'b0, 1'b0},
    '{1'b0, 17'h00404, 32'h0f0f0f0f, 1'b0, 1'b0, 1'b0},
    '{1'b1, 17'h00400, 32'h0, 1'b1, 1'b0, 1'b1},
    '{1'b0, 17'h00004, 32'h0, 1'b0, 1'b1, 1'b1},
    '{1'b1, 17'h00000, 32'h0, 1'b0, 1'b0, 1'b0},
    '{1'b1, 17'h1fc00, 32'h0, 1'b0, 1'b0, 1'b0},
    '{1'b0, 17'h1fffc, 32'ha5a5a5a5, 1'b0, 1'b0, 1'b0}};
  fbp_top dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .prot_ro_in(prot_ro_in),
    .prot_xo_in(prot_xo_in), .fetch_req_in(f_req), .fetch_addr_in(f_addr),
    .fetch_ack_out(f_ack), .fetch_data_out(f_data), .rd_req_in(r_req), .rd_dbg_in(r_dbg),
    .rd_addr_in(r_addr), .rd_ack_out(r_ack), .rd_err_out(r_err), .rd_data_out(r_data),
    .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in), .cmd_addr_in(cmd_addr_in),
    .cmd_data_in(cmd_data_in), .cmd_ready_out(c_rdy), .cmd_done_out(c_done),
    .cmd_err_out(c_err), .viol_out(viol), .viol_clear_in(viol_clear_in));
  fbp_host_model host (.clk_in(sys_clk_in), .fetch_ack_in(f_ack), .fetch_data_in(f_data),
    .rd_ack_in(r_ack), .rd_err_in(r_err), .rd_data_in(r_data), .fetch_req_out(f_req),
    .fetch_addr_out(f_addr), .rd_req_out(r_req), .rd_dbg_out(r_dbg), .rd_addr_out(r_addr));
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // six erases dominate the run, about 1600 cycles
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      results();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input fbp_row_t r, output int c);
    while (c_rdy !== 1'b1) @(posedge sys_clk_in) #1;
    cmd_valid_in = 1'b1;
    cmd_op_in = r.op;
    cmd_addr_in = r.a;
    cmd_data_in = r.d;
    @(posedge sys_clk_in) #1;
    cmd_valid_in = 1'b0;
    cmd_data_in = ~r.d;
    c = 0;
    while (c_done !== 1'b1 && c_err !== 1'b1 && c < 400) begin
      @(posedge sys_clk_in) #1;
      c++;
    end
  endtask
  task automatic results();
    $display("mismatches %0d, compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    {reset_in, cmd_valid_in, cmd_op_in, viol_clear_in} = 4'h8;
    {cmd_addr_in, cmd_data_in, prot_ro_in, prot_xo_in} = '0;
    repeat (12) @(posedge sys_clk_in);
    #1 reset_in = 1'b0;
    check({31'h0, viol}, 32'h0);
    check({31'h0, c_rdy}, 32'h1);
    // first request only after the edge that sees reset low
    @(posedge sys_clk_in) #1;
    // =====================================================
    // command table; pairs blocks 0 and 1 in unit 0
    foreach (rows[i]) begin
      prot_ro_in = {63'h0, rows[i].ro} << rows[i].a[16:11];
      prot_xo_in = {63'h0, rows[i].xo} << rows[i].a[16:11];
      cmd(rows[i], n);
      check({31'h0, c_err}, {31'h0, rows[i].err});
      check(n, (rows[i].op && !rows[i].err) ? 256 : 0);
      check({31'h0, viol}, {31'h0, rows[i].err});
      k = rows[i].op ? {rows[i].a[16:10], 10'h3fc} : rows[i].a;
      if (!rows[i].err && rows[i].op) begin
        exp_mem[{rows[i].a[16:10], 10'h004}] = `FBP_ERASED;
        exp_mem[k] = `FBP_ERASED;
      end
      if (!rows[i].err && !rows[i].op) exp_mem[k] = exp_mem[k] & rows[i].d;
      {prot_ro_in, prot_xo_in, viol_clear_in} = {128'h0, 1'b1};
      host.read(k[16:0], 1'b0, d, e);
      viol_clear_in = 1'b0;
      check(d, exp_mem[k]);
    end
    host.read(17'h00404, 1'b0, d, e);
    check(d, 32'h0f0f0f0f);
    prot_xo_in = 64'h4;
    host.fetch(17'h01004, d);
    check(d, `FBP_ERASED);
    check({31'h0, viol}, 32'h0);
    for (int s = 0; s < 2; s++) begin
      host.read(17'h01004, s[0], d, e);
      check(d, `FBP_DENIED_DATA);
      check({31'h0, e}, 32'h1);
      check({31'h0, viol}, 32'h1);
    end
    {prot_xo_in, prot_ro_in, viol_clear_in} = {64'h0, 64'h4, 1'b1};
    host.read(17'h01004, 1'b1, d, e);
    viol_clear_in = 1'b0;
    check(d, `FBP_ERASED);
    check({30'h0, e, viol}, 32'h0);
    // =====================================================
    // erase of an open unit: ready low in the cycle after acceptance, done after 256 words
    cmd_valid_in = 1'b1;
    cmd_op_in = 1'b1;
    cmd_addr_in = 17'h01800;
    @(posedge sys_clk_in) #1;
    cmd_valid_in = 1'b0;
    check({31'h0, c_rdy}, 32'h0);
    repeat (255) @(posedge sys_clk_in) #1;
    check({31'h0, c_done}, 32'h0);
    @(posedge sys_clk_in) #1;
    check({30'h0, c_done, c_rdy}, 32'h3);
    host.read(17'h01804, 1'b0, d, e);
    check(d, `FBP_ERASED);
    // a violation in the clear cycle keeps the flag up
    {prot_ro_in, prot_xo_in, viol_clear_in} = {64'h0, 64'h4, 1'b1};
    host.read(17'h01004, 1'b1, d, e);
    viol_clear_in = 1'b0;
    check({30'h0, e, viol}, 32'h3);
    // second reset: flags drop, array keeps its words
    reset_in = 1'b1;
    repeat (2) @(posedge sys_clk_in) #1;
    check({29'h0, viol, c_err, c_rdy}, 32'h1);
    reset_in = 1'b0;
    host.read(17'h00404, 1'b0, d, e);
    check(d, 32'h0f0f0f0f);
    results();
  end
endmodule // tb
